// >>> include/trk_io_pkg.sv
// How it works
// RULE1: four inputs, pulled up, float high
// RULE2: three outputs set by host or remote
// RULE3: per-line type plus rise/fall trigger enables
// RULE4: emergency-type trigger enters emergency tracking
// RULE5: test-type trigger enters test tracking
// RULE6: general-type trigger queues one input report; triggers on several general lines in one cycle queue only one report
// RULE7: input levels always offered to position reports
// RULE8: defaults: line0 emergency fall, line1 test fall
// RULE9: line 0 shared with onboard emergency button
// RULE10: momentary press starts emergency tracking anytime
// RULE11: momentary hold over three seconds exits emergency
// RULE12: lamp on while emergency tracking active
// RULE13: switch type momentary or latching, momentary default
// RULE14: latching: active level enables, opposite disables
// RULE15: pin report enabled: level change sends notice
// RULE16: fixed baud, default 19.2k, 4.8k to 115.2k
// RULE17: two-flop sync and debounce before edge detect
package trk_io_pkg;
    // system clock
    localparam int CLK_HZ = 10_000_000;
    // timing figures in their own unit
    localparam int HOLD_EXIT_MS = 3000;
    localparam int DEBOUNCE_MS = 5;
    localparam int HOLD_EXIT_CYCLES = HOLD_EXIT_MS * (CLK_HZ / 1000);
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
    // serial rates in bit/s
    localparam int BAUD_4800 = 4800;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int BAUD_38400 = 38400;
    localparam int BAUD_57600 = 57600;
    localparam int BAUD_115200 = 115200;
    // rate select codes
    typedef enum logic [2:0] {
        RATE_4800 = 3'h0,
        RATE_9600 = 3'h1,
        RATE_19200 = 3'h2,
        RATE_38400 = 3'h3,
        RATE_57600 = 3'h4,
        RATE_115200 = 3'h5
    } rate_t;
    // input line types
    typedef enum logic [1:0] {
        TYPE_EMERG = 2'h0,
        TYPE_TEST = 2'h1,
        TYPE_GENERAL = 2'h2
    } in_type_t;
    // per-line config nibble layout
    localparam int CFG_W = 4;
    localparam int CFG_TYPE_LSB = 0;
    localparam int CFG_RISE_BIT = 2;
    localparam int CFG_FALL_BIT = 3;
    // control register bits
    localparam int CTRL_LATCH_BIT = 0;
    localparam int CTRL_PREN_BIT = 1;
    // interrupt status bits
    localparam int INT_EMG_ON = 0;
    localparam int INT_EMG_OFF = 1;
    localparam int INT_TEST = 2;
    localparam int INT_REPORT = 3;
    localparam int INT_PIN = 4;
    localparam int INT_W = 5;
    // status register bits above the four levels
    localparam int STAT_EMG_BIT = 4;
    localparam int STAT_LATCH_BIT = 5;
    // register byte offsets
    localparam logic [7:0] ADDR_IN_CFG = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_OUT = 8'h08;
    localparam logic [7:0] ADDR_BAUD = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_INT_STAT = 8'h14;
    localparam logic [7:0] ADDR_INT_MASK = 8'h18;
    localparam logic [7:0] ADDR_REPORT = 8'h1c;
    // reset values
    localparam logic [15:0] IN_CFG_RST = 16'h2298;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [2:0] OUT_RST = 3'h0;
    localparam logic [4:0] INT_MASK_RST = 5'h00;
endpackage

// >>> core/tracker_io_trigger_logic.sv
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module tracker_io_trigger_logic #(
    parameter int DEBOUNCE_CYCLES = trk_io_pkg::DEBOUNCE_CYCLES,
    parameter int HOLD_CYCLES = trk_io_pkg::HOLD_EXIT_CYCLES
)
(
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [3:0] IN_LINE_I,
    input wire logic EMERG_BUTTON_N_I,
    input wire logic REMOTE_OUT_WE_I,
    input wire logic [2:0] REMOTE_OUT_I,
    output logic [2:0] OUT_LINE_O,
    output logic EMERG_LAMP_O,
    output logic EMERG_TRACK_O,
    output logic TEST_TRACK_O,
    output logic INPUT_REPORT_O,
    output logic PIN_NOTICE_O,
    output logic [3:0] INPUT_LEVELS_O,
    output logic BAUD_TICK_O,
    output logic IRQ_O
);

    // emergency state machine codes
    typedef enum logic [1:0] {
        EMG_OFF = 2'b00,
        EMG_HELD = 2'b01,
        EMG_ARMED = 2'b10
    } emg_state_t;
    // divisor for one bit time at the selected rate
    function automatic logic [15:0] baud_div(input logic [2:0] code);
        int bps;
        unique case (code)
            trk_io_pkg::RATE_4800: bps = trk_io_pkg::BAUD_4800;
            trk_io_pkg::RATE_9600: bps = trk_io_pkg::BAUD_9600;
            trk_io_pkg::RATE_19200: bps = trk_io_pkg::BAUD_19200;
            trk_io_pkg::RATE_38400: bps = trk_io_pkg::BAUD_38400;
            trk_io_pkg::RATE_57600: bps = trk_io_pkg::BAUD_57600;
            trk_io_pkg::RATE_115200: bps = trk_io_pkg::BAUD_115200;
            default: bps = trk_io_pkg::BAUD_19200;
        endcase
        return 16'(trk_io_pkg::CLK_HZ / bps - 1);
    endfunction
    // true when a rate code names a supported rate
    function automatic logic rate_ok(input logic [2:0] code);
        return code <= trk_io_pkg::RATE_115200;
    endfunction
    // synchroniser stages: bits 3:0 input lines, bit 4 button
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    // debounced levels and their counters
    logic [3:0] deb_reg, deb_next;
    logic [15:0] dcnt_reg [4];
    logic [15:0] dcnt_next [4];
    // one-cycle edge pulses aligned with the debounced level
    logic [3:0] rise_reg, rise_next;
    logic [3:0] fall_reg, fall_next;
    // combined line 0 level, button and external pin
    logic [3:0] raw_lvl;
    // emergency tracking state and hold timer
    emg_state_t emg_reg, emg_next;
    logic [24:0] hold_reg, hold_next;
    logic emg_on_reg, emg_on_next;
    // trigger pulses to the tracking logic
    logic test_reg, test_next;
    logic report_reg, report_next;
    logic notice_reg, notice_next;
    // decoded trigger terms
    logic [3:0] hit;
    logic emg_hit, test_hit;
    logic [2:0] gen_hits;
    logic emg_level;
    logic ev_emg_on, ev_emg_off;
    // software registers
    logic [15:0] cfg_reg, cfg_next;
    logic [1:0] ctrl_reg, ctrl_next;
    logic [2:0] out_reg, out_next;
    logic [2:0] rate_reg, rate_next;
    logic [4:0] int_reg, int_next;
    logic [4:0] mask_reg, mask_next;
    logic [7:0] queue_reg, queue_next;
    logic irq_reg, irq_next;
    // apb answer
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic wr_en, rd_en;
    logic [4:0] events;
    // baud tick divider
    logic [15:0] bcnt_reg, bcnt_next;
    logic btick_reg, btick_next;

    // two flops on each pin; the pad pull-up keeps an open line high, so reset high
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            sync1_reg <= 5'h1f; // see RULE1
            sync2_reg <= 5'h1f;
        end
        else
        begin
            sync1_reg <= {EMERG_BUTTON_N_I, IN_LINE_I}; // see RULE17
            sync2_reg <= sync1_reg;
        end
    end
    // debounce: a level must hold for the whole window before it is accepted
    always_comb
    begin
        raw_lvl = sync2_reg[3:0];
        raw_lvl[0] = sync2_reg[0] & sync2_reg[4]; // see RULE9
        deb_next = deb_reg;
        rise_next = 4'h0;
        fall_next = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            dcnt_next[i] = 16'h0000;
            if (raw_lvl[i] != deb_reg[i])
            begin
                // level differs: count, flip at end of window
                if (dcnt_reg[i] == 16'(DEBOUNCE_CYCLES - 1))
                begin
                    deb_next[i] = raw_lvl[i]; // see RULE17
                    rise_next[i] = raw_lvl[i];
                    fall_next[i] = ~raw_lvl[i];
                end
                else
                    dcnt_next[i] = dcnt_reg[i] + 16'h0001;
            end
        end
    end

    // debounce registers
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            deb_reg <= 4'hf;
            rise_reg <= 4'h0;
            fall_reg <= 4'h0;
            dcnt_reg <= '{default: 16'h0000};
        end
        else
        begin
            deb_reg <= deb_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
            dcnt_reg <= dcnt_next;
        end
    end

    // trigger decode per line and emergency state machine
    always_comb
    begin
        emg_hit = 1'b0;
        test_hit = 1'b0;
        gen_hits = 3'h0;
        emg_level = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            // enabled edge on this line
            hit[i] = (cfg_reg[i * 4 + trk_io_pkg::CFG_RISE_BIT] & rise_reg[i])
                   | (cfg_reg[i * 4 + trk_io_pkg::CFG_FALL_BIT] & fall_reg[i]); // see RULE3
            unique case (cfg_reg[i * 4 +: 2])
                trk_io_pkg::TYPE_EMERG:
                begin
                    emg_hit = emg_hit | hit[i]; // see RULE4
                    // active level: low when falling edge triggers, else high when rising edge does
                    if (cfg_reg[i * 4 + trk_io_pkg::CFG_FALL_BIT])
                        emg_level = emg_level | ~deb_reg[i]; // see RULE14
                    else if (cfg_reg[i * 4 + trk_io_pkg::CFG_RISE_BIT])
                        emg_level = emg_level | deb_reg[i];
                end
                trk_io_pkg::TYPE_TEST: test_hit = test_hit | hit[i]; // see RULE5
                trk_io_pkg::TYPE_GENERAL: gen_hits = gen_hits + {2'b00, hit[i]}; // see RULE6
                default: ; // reserved type code: line does nothing
            endcase
        end
        emg_next = emg_reg;
        hold_next = 25'h0000000;
        if (ctrl_reg[trk_io_pkg::CTRL_LATCH_BIT])
        begin
            // latching: follow the active level directly
            emg_next = emg_level ? EMG_HELD : EMG_OFF; // see RULE14
        end
        else
        begin
            unique case (emg_reg)
                EMG_OFF:
                begin
                    // a press starts tracking whenever idle
                    if (emg_hit)
                        emg_next = EMG_HELD; // see RULE10
                end
                EMG_HELD:
                begin
                    // wait for the starting press to be released
                    if (!emg_level)
                        emg_next = EMG_ARMED;
                end
                EMG_ARMED:
                begin
                    // a long hold ends tracking
                    if (emg_level)
                    begin
                        if (hold_reg >= 25'(HOLD_CYCLES))
                            emg_next = EMG_OFF; // see RULE11
                        else
                            hold_next = hold_reg + 25'h0000001;
                    end
                end
                default: emg_next = EMG_OFF;
            endcase
        end
        emg_on_next = (emg_next != EMG_OFF); // see RULE12
        ev_emg_on = emg_on_next & ~emg_on_reg;
        ev_emg_off = ~emg_on_next & emg_on_reg;
        test_next = test_hit;
        report_next = (gen_hits != 3'h0);
        // notice on any accepted level change while enabled
        notice_next = ctrl_reg[trk_io_pkg::CTRL_PREN_BIT] & ((rise_reg | fall_reg) != 4'h0); // see RULE15
    end

    // trigger state registers
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            emg_reg <= EMG_OFF;
            hold_reg <= 25'h0000000;
            emg_on_reg <= 1'b0;
            test_reg <= 1'b0;
            report_reg <= 1'b0;
            notice_reg <= 1'b0;
        end
        else
        begin
            emg_reg <= emg_next;
            hold_reg <= hold_next;
            emg_on_reg <= emg_on_next;
            test_reg <= test_next;
            report_reg <= report_next;
            notice_reg <= notice_next;
        end
    end

    // apb slave, register file and interrupt bits
    always_comb
    begin
        wr_en = PSEL_I & PENABLE_I & pready_reg & PWRITE_I;
        rd_en = PSEL_I & PENABLE_I & ~pready_reg & ~PWRITE_I;
        cfg_next = cfg_reg;
        ctrl_next = ctrl_reg;
        out_next = out_reg;
        rate_next = rate_reg;
        mask_next = mask_reg;
        int_next = int_reg;
        queue_next = queue_reg;
        // one wait state: ready rises in the second access cycle
        pready_next = PSEL_I & PENABLE_I & ~pready_reg;
        pslverr_next = 1'b0;
        prdata_next = 32'h00000000;
        if (PSEL_I & PENABLE_I & ~pready_reg)
        begin
            // decode once, answer with ready
            unique case (PADDR_I)
                trk_io_pkg::ADDR_IN_CFG: prdata_next = {16'h0000, cfg_reg};
                trk_io_pkg::ADDR_CTRL: prdata_next = {30'h00000000, ctrl_reg};
                trk_io_pkg::ADDR_OUT: prdata_next = {29'h00000000, out_reg};
                trk_io_pkg::ADDR_BAUD: prdata_next = {29'h00000000, rate_reg};
                trk_io_pkg::ADDR_STATUS: prdata_next = {26'h0000000, ctrl_reg[0], emg_on_reg, deb_reg};
                trk_io_pkg::ADDR_INT_STAT: prdata_next = {27'h0000000, int_reg};
                trk_io_pkg::ADDR_INT_MASK: prdata_next = {27'h0000000, mask_reg};
                trk_io_pkg::ADDR_REPORT: prdata_next = {24'h000000, queue_reg};
                default: pslverr_next = 1'b1;
            endcase
            if (!rd_en)
                prdata_next = 32'h00000000;
        end
        // remote update of the outputs
        if (REMOTE_OUT_WE_I)
            out_next = REMOTE_OUT_I; // see RULE2
        if (wr_en)
        begin
            unique case (PADDR_I)
                trk_io_pkg::ADDR_IN_CFG: cfg_next = PWDATA_I[15:0]; // see RULE3
                trk_io_pkg::ADDR_CTRL: ctrl_next = PWDATA_I[1:0]; // see RULE13
                trk_io_pkg::ADDR_OUT: out_next = PWDATA_I[2:0]; // see RULE2
                // unsupported rate codes leave the rate alone
                trk_io_pkg::ADDR_BAUD: if (rate_ok(PWDATA_I[2:0])) rate_next = PWDATA_I[2:0]; // see RULE16
                trk_io_pkg::ADDR_INT_STAT: int_next = int_reg & ~PWDATA_I[4:0];
                trk_io_pkg::ADDR_INT_MASK: mask_next = PWDATA_I[4:0];
                // host takes one report off the queue
                trk_io_pkg::ADDR_REPORT: if (queue_reg != 8'h00) queue_next = queue_reg - 8'h01;
                default: ;
            endcase
        end
        // new reports enter the queue, saturating
        if (report_reg && queue_next != 8'hff)
            queue_next = queue_next + 8'h01; // see RULE6
        // hardware set wins over a write-one clear in the same cycle
        events = 5'h00;
        events[trk_io_pkg::INT_EMG_ON] = ev_emg_on;
        events[trk_io_pkg::INT_EMG_OFF] = ev_emg_off;
        events[trk_io_pkg::INT_TEST] = test_reg;
        events[trk_io_pkg::INT_REPORT] = report_reg;
        events[trk_io_pkg::INT_PIN] = notice_reg;
        int_next = int_next | events;
        irq_next = (int_next & mask_next) != 5'h00;
    end

    // register file registers
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            cfg_reg <= trk_io_pkg::IN_CFG_RST; // see RULE8
            ctrl_reg <= trk_io_pkg::CTRL_RST; // see RULE13
            out_reg <= trk_io_pkg::OUT_RST;
            rate_reg <= trk_io_pkg::RATE_19200; // see RULE16
            int_reg <= 5'h00;
            mask_reg <= trk_io_pkg::INT_MASK_RST;
            queue_reg <= 8'h00;
            irq_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            ctrl_reg <= ctrl_next;
            out_reg <= out_next;
            rate_reg <= rate_next;
            int_reg <= int_next;
            mask_reg <= mask_next;
            queue_reg <= queue_next;
            irq_reg <= irq_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // bit-rate enable: one pulse per bit time, restarts on a rate change
    always_comb
    begin
        btick_next = 1'b0;
        if (rate_next != rate_reg)
            bcnt_next = 16'h0000;
        else if (bcnt_reg >= baud_div(rate_reg))
        begin
            bcnt_next = 16'h0000;
            btick_next = 1'b1; // see RULE16
        end
        else
            bcnt_next = bcnt_reg + 16'h0001;
    end
    // bit-rate divider registers
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            bcnt_reg <= 16'h0000;
            btick_reg <= 1'b0;
        end
        else
        begin
            bcnt_reg <= bcnt_next;
            btick_reg <= btick_next;
        end
    end

    // every output straight from a flop
    assign PRDATA_O = prdata_reg;
    assign PREADY_O = pready_reg;
    assign PSLVERR_O = pslverr_reg;
    assign OUT_LINE_O = out_reg;
    assign EMERG_LAMP_O = emg_on_reg; // see RULE12
    assign EMERG_TRACK_O = emg_on_reg;
    assign TEST_TRACK_O = test_reg;
    assign INPUT_REPORT_O = report_reg;
    assign PIN_NOTICE_O = notice_reg;
    assign INPUT_LEVELS_O = deb_reg; // see RULE7
    assign BAUD_TICK_O = btick_reg;
    assign IRQ_O = irq_reg;

endmodule
`default_nettype wire

// >>> verif/trk_io_checker.sv
`timescale 1ns/1ns
`default_nettype none
module trk_io_checker #(
    parameter int DEBOUNCE_CYCLES = 4,
    parameter int HOLD_CYCLES = 20
)
(
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [3:0] IN_LINE_I,
    input wire logic EMERG_BUTTON_N_I,
    input wire logic REMOTE_OUT_WE_I,
    input wire logic [2:0] REMOTE_OUT_I,
    input wire logic [2:0] OUT_LINE_O,
    input wire logic EMERG_LAMP_O,
    input wire logic EMERG_TRACK_O,
    input wire logic TEST_TRACK_O,
    input wire logic INPUT_REPORT_O,
    input wire logic PIN_NOTICE_O,
    input wire logic [3:0] INPUT_LEVELS_O
);
    // pin levels as the block sees them, button merged into line 0
    wire logic [3:0] pins = IN_LINE_I & {3'h7, EMERG_BUTTON_N_I};
    // cycles that merged line 0 has been held low
    int low_cnt;
    int low_next;
    // count while low, saturating, so a long hold cannot wrap
    always_comb
    begin
        low_next = pins[0] ? 0 : (low_cnt < 1000000 ? low_cnt + 1 : low_cnt);
    end
    // register the hold count
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            low_cnt <= 0;
        else
            low_cnt <= low_next;
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);
    // bus phases
    sequence s_setup;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence s_access;
        PSEL_I && PENABLE_I;
    endsequence
    a_ready_one_wait: assert property (s_setup ##1 s_access |-> !PREADY_O ##1 PREADY_O)
        else $error("ready not in second access cycle");
    a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_ready_in_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
        else $error("ready outside access phase");
    a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    a_lamp_follows: assert property (EMERG_LAMP_O == EMERG_TRACK_O)
        else $error("lamp differs from emergency state");
    a_test_single: assert property (TEST_TRACK_O |=> !TEST_TRACK_O)
        else $error("test trigger repeated");
    a_report_single: assert property (INPUT_REPORT_O |=> !INPUT_REPORT_O)
        else $error("report trigger repeated");
    a_notice_cause: assert property (PIN_NOTICE_O |-> INPUT_LEVELS_O != $past(INPUT_LEVELS_O, 3))
        else $error("notice without level change");
    a_levels_settled: assert property (!$stable(INPUT_LEVELS_O) |-> INPUT_LEVELS_O == $past(pins, DEBOUNCE_CYCLES))
        else $error("level changed before debounce");
    a_remote_load: assert property (REMOTE_OUT_WE_I && !(PSEL_I && PENABLE_I && PWRITE_I && PREADY_O)
        |=> OUT_LINE_O == $past(REMOTE_OUT_I))
        else $error("remote output not loaded");
    a_hold_exit: assert property ($fell(EMERG_TRACK_O) |-> low_cnt == 0 || low_cnt > HOLD_CYCLES)
        else $error("emergency left before hold time");
endmodule
bind tracker_io_trigger_logic trk_io_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) chk_i (
    .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .IN_LINE_I(IN_LINE_I), .EMERG_BUTTON_N_I(EMERG_BUTTON_N_I),
    .REMOTE_OUT_WE_I(REMOTE_OUT_WE_I), .REMOTE_OUT_I(REMOTE_OUT_I), .OUT_LINE_O(OUT_LINE_O),
    .EMERG_LAMP_O(EMERG_LAMP_O), .EMERG_TRACK_O(EMERG_TRACK_O), .TEST_TRACK_O(TEST_TRACK_O),
    .INPUT_REPORT_O(INPUT_REPORT_O), .PIN_NOTICE_O(PIN_NOTICE_O), .INPUT_LEVELS_O(INPUT_LEVELS_O));
`default_nettype wire

// >>> verif/io_switch_model.sv
`timescale 1ns/1ns
`default_nettype none
module io_switch_model
(
    input wire logic [3:0] pull_low_i, // equipment pulls the line low
    input wire logic press_i, // onboard button held
    output logic [3:0] line_o, // levels at the pins
    output logic btn_n_o // button contact, low while held
);
    // a released line floats high through the pad pull-up
    always_comb
    begin
        line_o = ~pull_low_i;
        btn_n_o = ~press_i;
    end
endmodule
`default_nettype wire

// >>> verif/tracker_io_trigger_logic_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tracker_io_trigger_logic_tb_top;
    localparam int DB = 4; // shortened debounce
    localparam int HOLD = 20; // shortened hold-to-exit
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, perr, last_err;
    logic [31:0] rd_val;
    logic [3:0] pull = 4'h0; // lines pulled low
    logic press = 1'b0;
    logic rwe = 1'b0;
    logic [2:0] rout = 3'h0;
    logic [3:0] line, lvl;
    logic [2:0] outl;
    logic btn_n, lamp, etrk, ttrk, rpt, ntc, tick, irq;
    int bad_count = 0;
    int tests_run = 0;
    // 100 ns clock
    always #50 mclk = ~mclk;
    io_switch_model sw (.pull_low_i(pull), .press_i(press), .line_o(line), .btn_n_o(btn_n));
    tracker_io_trigger_logic #(.DEBOUNCE_CYCLES(DB), .HOLD_CYCLES(HOLD)) dut (
        .MCLK_I(mclk), .RESETN_I(resetn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
        .IN_LINE_I(line), .EMERG_BUTTON_N_I(btn_n), .REMOTE_OUT_WE_I(rwe), .REMOTE_OUT_I(rout),
        .OUT_LINE_O(outl), .EMERG_LAMP_O(lamp), .EMERG_TRACK_O(etrk), .TEST_TRACK_O(ttrk),
        .INPUT_REPORT_O(rpt), .PIN_NOTICE_O(ntc), .INPUT_LEVELS_O(lvl), .BAUD_TICK_O(tick), .IRQ_O(irq));
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one bus transfer, held until ready is sampled high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge mclk);
        end
        rd_val = prdata;
        last_err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 50)
            bad_count++;
        @(negedge mclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_val, exp);
    endtask
    task cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    // pull a line low (1) or let it go (0)
    task pin(input int i, input logic low);
        @(posedge mclk);
        pull[i] <= low;
    endtask
    // wait, bounded, for an output to reach a value; n counts cycles
    task wfor(input int s, input logic v, output int n);
        logic x;
        n = 0;
        x = ~v;
        while (x !== v && n < 200)
        begin
            @(negedge mclk);
            n++;
            case (s)
                0: x = ttrk;
                1: x = rpt;
                2: x = ntc;
                4: x = tick;
                default: x = etrk;
            endcase
        end
        chk({31'h0, x}, {31'h0, v});
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog, far beyond the expected run
    initial
    begin
        #2000000;
        bad_count++;
        close_out();
    end
    // test sequence
    initial
    begin
        int n;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        rd(trk_io_pkg::ADDR_IN_CFG, 32'h2298);
        rd(trk_io_pkg::ADDR_CTRL, 32'h0);
        rd(trk_io_pkg::ADDR_BAUD, 32'h2);
        rd(trk_io_pkg::ADDR_STATUS, 32'hf);
        rd(8'h20, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            wr(trk_io_pkg::ADDR_BAUD, i);
            rd(trk_io_pkg::ADDR_BAUD, i);
        end
        wr(trk_io_pkg::ADDR_BAUD, 32'h7);
        rd(trk_io_pkg::ADDR_BAUD, 32'h5);
        wfor(4, 1'b1, n);
        wfor(4, 1'b0, n);
        wfor(4, 1'b1, n);
        chk(n, trk_io_pkg::CLK_HZ / trk_io_pkg::BAUD_115200 - 1);
        wr(trk_io_pkg::ADDR_OUT, 32'h5);
        chk(outl, 32'h5);
        @(posedge mclk);
        rwe <= 1'b1;
        rout <= 3'h3;
        @(posedge mclk);
        rwe <= 1'b0;
        cyc(1);
        chk(outl, 32'h3);
        $display("done: registers and outputs");
        wr(trk_io_pkg::ADDR_INT_MASK, 32'h1f);
        pin(1, 1'b1);
        wfor(0, 1'b1, n);
        cyc(3);
        chk(irq, 32'h1);
        apb(1'b0, trk_io_pkg::ADDR_INT_STAT, 32'h0);
        chk(rd_val & 32'h4, 32'h4);
        wr(trk_io_pkg::ADDR_INT_MASK, 32'h0);
        cyc(2);
        chk(irq, 32'h0);
        pin(1, 1'b0);
        cyc(20);
        wr(trk_io_pkg::ADDR_INT_MASK, 32'h1f);
        cyc(2);
        chk(irq, 32'h1);
        wr(trk_io_pkg::ADDR_INT_STAT, 32'h1f);
        cyc(2);
        chk(irq, 32'h0);
        $display("done: test trigger and interrupt");
        wr(trk_io_pkg::ADDR_IN_CFG, 32'h2698);
        pin(2, 1'b1);
        cyc(20);
        rd(trk_io_pkg::ADDR_REPORT, 32'h0);
        pin(2, 1'b0);
        wfor(1, 1'b1, n);
        rd(trk_io_pkg::ADDR_REPORT, 32'h1);
        wr(trk_io_pkg::ADDR_REPORT, 32'h0);
        rd(trk_io_pkg::ADDR_REPORT, 32'h0);
        $display("done: general trigger");
        wr(trk_io_pkg::ADDR_CTRL, 32'h2);
        pin(3, 1'b1);
        wfor(2, 1'b1, n);
        chk(lvl, 32'h7);
        pin(3, 1'b0);
        wfor(2, 1'b1, n);
        chk(lvl, 32'hf);
        wr(trk_io_pkg::ADDR_CTRL, 32'h0);
        $display("done: pin notice");
        @(posedge mclk);
        press <= 1'b1;
        wfor(3, 1'b1, n);
        chk(lamp, 32'h1);
        @(posedge mclk);
        press <= 1'b0;
        cyc(20);
        chk(etrk, 32'h1);
        pin(0, 1'b1);
        wfor(3, 1'b0, n);
        chk(n > HOLD, 32'h1);
        chk(lamp, 32'h0);
        pin(0, 1'b0);
        cyc(20);
        chk(etrk, 32'h0);
        $display("done: momentary emergency");
        wr(trk_io_pkg::ADDR_CTRL, 32'h1);
        pin(0, 1'b1);
        wfor(3, 1'b1, n);
        pin(0, 1'b0);
        wfor(3, 1'b0, n);
        $display("done: latching emergency");
        close_out();
    end
endmodule
`default_nettype wire
